// ==== tbp_pkg.sv ====
`default_nettype none
package tbp_pkg;
  // ------------------------------------------------------------
  // Register addresses on the CPU port.
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_D_PIN_VALUES = 3'h0;
  localparam logic [2:0] ADDR_D_OUTPUT_LATCH = 3'h1;
  localparam logic [2:0] ADDR_D_DIRECTION = 3'h2;
  localparam logic [2:0] ADDR_E_PIN_VALUES = 3'h3;
  localparam logic [2:0] ADDR_E_OUTPUT_LATCH = 3'h4;
  localparam logic [2:0] ADDR_E_DIR_CTRL = 3'h5;
  localparam logic [2:0] ADDR_ANALOG_CONFIG = 3'h6;
  localparam logic [2:0] ADDR_MASTER_CTRL = 3'h7;
  // ------------------------------------------------------------
  // Direction and slave control register fields.
  // ------------------------------------------------------------
  localparam int BIT_INPUT_BYTE_WAITING = 7;
  localparam int BIT_OUTPUT_BYTE_PENDING = 6;
  localparam int BIT_INPUT_OVERRUN = 5;
  localparam int BIT_SLAVE_PORT_SELECT = 4;
  localparam int BIT_READ_STROBE = 0;
  localparam int BIT_WRITE_STROBE = 1;
  localparam int BIT_CHIP_SELECT = 2;
  // ------------------------------------------------------------
  // Reset values.
  // ------------------------------------------------------------
  localparam logic [7:0] RST_D_DIRECTION = 8'hff;
  localparam logic [2:0] RST_E_DIRECTION = 3'h7;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [2:0] RST_ANALOG_CONFIG = 3'h0;
  localparam logic [2:0] ANALOG_ALL_DIGITAL = 3'h7;
  // ------------------------------------------------------------
  // Master timing: each strobe is held low STROBE_CYCLES + 1 cycles.
  // ------------------------------------------------------------
  localparam int STROBE_NS = 160;
  localparam int CLK_NS = 40;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] MCMD_WRITE = 8'h01;
  localparam logic [7:0] MCMD_READ = 8'h02;
  localparam logic [2:0] MADDR_DATA = 3'h0;
  localparam logic [2:0] MADDR_CMD = 3'h1;
endpackage
`default_nettype wire

// ==== tbp_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface tbp_link_if;
  logic [7:0] d_dev_out;
  logic [7:0] d_dev_oe;
  logic [2:0] e_dev_out;
  logic [2:0] e_dev_oe;
  logic [7:0] d_mst_out;
  logic [7:0] d_mst_oe;
  logic [2:0] e_mst_out;
  logic [2:0] e_mst_oe;
  logic [7:0] d_level;
  logic [2:0] e_level;
  // ------------------------------------------------------------
  // Wire resolution: a driven bit wins, an idle bit floats high.
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      d_level[i] = d_dev_oe[i] ? d_dev_out[i] : (d_mst_oe[i] ? d_mst_out[i] : 1'b1);
    end
    for (int i = 0; i < 3; i++) begin
      e_level[i] = e_dev_oe[i] ? e_dev_out[i] : (e_mst_oe[i] ? e_mst_out[i] : 1'b1);
    end
  end
  modport device (output d_dev_out, d_dev_oe, e_dev_out, e_dev_oe, input d_level, e_level);
  modport master (output d_mst_out, d_mst_oe, e_mst_out, e_mst_oe, input d_level, e_level);
endinterface
`default_nettype wire

// ==== tbp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module tbp_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  if (WIDTH < 1) begin : g_width_check
    $error("WIDTH must be at least one");
  end
  logic [WIDTH-1:0] meta_q;
  // ------------------------------------------------------------
  // Two-stage synchroniser; only the second stage is read.
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== tbp_port_device.sv ====
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Three pins, each with direction bit.
// - Direction one tri-states the pin.
// - Direction zero drives the output latch.
// - Latch readable separately, returns latched value.
// - Analog-selected pins read as zero.
// - Direction bits still drive analog pins.
// - Reset makes all three pins analog.
// - Bit 7: received byte awaits CPU.
// - Bit 6: output byte not yet read.
// - Bit 5 overrun, cleared only by software.
// - Bit 4 selects slave port mode.
// - Bit 3 always reads zero.
// - Bits 2..0 are pin directions.
// - Pin 0 is active-low read strobe.
// - Pin 1 is active-low write strobe.
// - Pin 2 is active-low chip select.
// - Data pins are I/O or bus bits.
// - Write taken when select and write low.
// - Read served when select and read low.
// - Software sets inputs and digital pins first.
module tbp_port_device (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // CPU register port
  input wire logic [2:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  // Pin side
  tbp_link_if.device link
);
  logic [7:0] d_latch_q;
  logic [7:0] d_dir_q;
  logic [2:0] e_latch_q;
  logic [2:0] e_dir_q;
  logic [2:0] analog_cfg_q;
  logic slave_sel_q;
  logic in_wait_q;
  logic out_pend_q;
  logic overrun_q;
  logic [7:0] d_pins_s;
  logic [2:0] e_pins_s;
  logic ext_wr_q;
  logic ext_rd_q;
  logic [7:0] d_oe_q;
  logic [2:0] e_oe_q;
  logic [7:0] d_out_q;
  logic [2:0] e_out_q;

  tbp_sync #(.WIDTH(8), .RESET_VAL(8'hff)) u_sync_d (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(link.d_level),
    .sync_out(d_pins_s)
  );
  tbp_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync_e (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(link.e_level),
    .sync_out(e_pins_s)
  );

  // An analog config of all ones makes every control pin digital.
  function automatic logic [2:0] digital_mask(input logic [2:0] cfg);
    digital_mask = (cfg == tbp_pkg::ANALOG_ALL_DIGITAL) ? 3'h7 : 3'h0;
  endfunction

  function automatic logic cpu_hit(input logic [2:0] a, input logic [2:0] reg_addr);
    cpu_hit = (a == reg_addr);
  endfunction

  // ------------------------------------------------------------
  // External strobe decode.
  // ------------------------------------------------------------
  logic sel_s;
  logic wr_act;
  logic rd_act;
  logic ext_wr_start;
  logic ext_rd_start;
  always_comb begin
    sel_s = slave_sel_q && !e_pins_s[tbp_pkg::BIT_CHIP_SELECT];
    wr_act = sel_s && !e_pins_s[tbp_pkg::BIT_WRITE_STROBE];
    rd_act = sel_s && !e_pins_s[tbp_pkg::BIT_READ_STROBE];
    ext_wr_start = wr_act && !ext_wr_q;
    ext_rd_start = rd_act && !ext_rd_q;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_wr_q <= 1'b0;
      ext_rd_q <= 1'b0;
    end else begin
      ext_wr_q <= wr_act;
      ext_rd_q <= rd_act;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers written by the CPU.
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      d_dir_q <= tbp_pkg::RST_D_DIRECTION;
      e_dir_q <= tbp_pkg::RST_E_DIRECTION;
      e_latch_q <= tbp_pkg::RST_LATCH[2:0];
      analog_cfg_q <= tbp_pkg::RST_ANALOG_CONFIG;
      slave_sel_q <= 1'b0;
    end else if (cpu_wr) begin
      if (cpu_hit(cpu_addr, tbp_pkg::ADDR_D_DIRECTION)) begin
        d_dir_q <= cpu_wdata;
      end
      if (cpu_hit(cpu_addr, tbp_pkg::ADDR_E_DIR_CTRL)) begin
        e_dir_q <= cpu_wdata[2:0];
        slave_sel_q <= cpu_wdata[tbp_pkg::BIT_SLAVE_PORT_SELECT];
      end
      // Pin and latch addresses both land in the latch.
      if (cpu_hit(cpu_addr, tbp_pkg::ADDR_E_PIN_VALUES) ||
          cpu_hit(cpu_addr, tbp_pkg::ADDR_E_OUTPUT_LATCH)) begin
        e_latch_q <= cpu_wdata[2:0];
      end
      if (cpu_hit(cpu_addr, tbp_pkg::ADDR_ANALOG_CONFIG)) begin
        analog_cfg_q <= cpu_wdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Data latch: shared by the CPU and the external master.
  // ------------------------------------------------------------
  logic cpu_d_wr;
  logic cpu_d_rd;
  assign cpu_d_wr = cpu_wr && (cpu_hit(cpu_addr, tbp_pkg::ADDR_D_PIN_VALUES) ||
                               cpu_hit(cpu_addr, tbp_pkg::ADDR_D_OUTPUT_LATCH));
  assign cpu_d_rd = cpu_rd && cpu_hit(cpu_addr, tbp_pkg::ADDR_D_PIN_VALUES);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      d_latch_q <= tbp_pkg::RST_LATCH;
    end else if (ext_wr_start) begin
      // The master's byte wins a same-cycle collision; it cannot be retried.
      d_latch_q <= d_pins_s;
    end else if (cpu_d_wr) begin
      d_latch_q <= cpu_wdata;
    end
  end

  // ------------------------------------------------------------
  // Status flags; a set wins over a clear.
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_wait_q <= 1'b0;
      out_pend_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (ext_wr_start) begin
        in_wait_q <= 1'b1;
      end else if (cpu_d_rd) begin
        in_wait_q <= 1'b0;
      end
      if (cpu_d_wr && slave_sel_q) begin
        out_pend_q <= 1'b1;
      end else if (ext_rd_start) begin
        out_pend_q <= 1'b0;
      end
      if (ext_wr_start && in_wait_q) begin
        overrun_q <= 1'b1;
      end else if (cpu_wr && cpu_hit(cpu_addr, tbp_pkg::ADDR_E_DIR_CTRL) &&
                   !cpu_wdata[tbp_pkg::BIT_INPUT_OVERRUN]) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drivers.
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      d_oe_q <= 8'h00;
      d_out_q <= 8'h00;
      e_oe_q <= 3'h0;
      e_out_q <= 3'h0;
    end else begin
      // In slave mode the bus is driven only while a read is held.
      d_oe_q <= slave_sel_q ? {8{rd_act}} : ~d_dir_q;
      d_out_q <= d_latch_q;
      e_oe_q <= ~e_dir_q;
      e_out_q <= e_latch_q;
    end
  end
  assign link.d_dev_oe = d_oe_q;
  assign link.d_dev_out = d_out_q;
  assign link.e_dev_oe = e_oe_q;
  assign link.e_dev_out = e_out_q;

  // ------------------------------------------------------------
  // CPU read data, one cycle after the strobe.
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      case (cpu_addr)
        tbp_pkg::ADDR_D_PIN_VALUES: cpu_rdata <= slave_sel_q ? d_latch_q : d_pins_s;
        tbp_pkg::ADDR_D_OUTPUT_LATCH: cpu_rdata <= d_latch_q;
        tbp_pkg::ADDR_D_DIRECTION: cpu_rdata <= d_dir_q;
        tbp_pkg::ADDR_E_PIN_VALUES: cpu_rdata <= {5'h00, e_pins_s & digital_mask(analog_cfg_q)};
        tbp_pkg::ADDR_E_OUTPUT_LATCH: cpu_rdata <= {5'h00, e_latch_q};
        tbp_pkg::ADDR_E_DIR_CTRL: cpu_rdata <= {in_wait_q, out_pend_q, overrun_q, slave_sel_q,
                                                1'b0, e_dir_q};
        tbp_pkg::ADDR_ANALOG_CONFIG: cpu_rdata <= {5'h00, analog_cfg_q};
        default: cpu_rdata <= 8'h00;
      endcase
    end else begin
      cpu_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ==== tbp_port_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module tbp_port_master #(
  parameter int HOLD_CYCLES = tbp_pkg::STROBE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Command port
  input wire logic [2:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [7:0] cmd_rdata,
  // Pin side
  tbp_link_if.master link
);
  // The device answers a read three edges after the strobe falls, so a shorter hold misses it.
  if (HOLD_CYCLES < 4 || HOLD_CYCLES > 255) begin : g_hold_check
    $error("HOLD_CYCLES out of range");
  end

  typedef enum logic [1:0] {
    TBP_IDLE = 2'b00,
    TBP_WRITE = 2'b01,
    TBP_READ = 2'b10
  } tbp_mstate_t;

  tbp_mstate_t state_q;
  logic [7:0] cnt_q;
  logic [7:0] wdata_q;
  logic [7:0] rbyte_q;
  logic busy_q;

  // ------------------------------------------------------------
  // Access sequencer: address 0 loads data, address 1 starts a cycle.
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= TBP_IDLE;
      cnt_q <= 8'h00;
      wdata_q <= 8'h00;
      rbyte_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        TBP_IDLE: begin
          if (cmd_wr && cmd_addr == tbp_pkg::MADDR_DATA) begin
            wdata_q <= cmd_wdata;
          end
          if (cmd_wr && cmd_addr == tbp_pkg::MADDR_CMD) begin
            cnt_q <= 8'h00;
            if (cmd_wdata == tbp_pkg::MCMD_WRITE) begin
              state_q <= TBP_WRITE;
              busy_q <= 1'b1;
            end else if (cmd_wdata == tbp_pkg::MCMD_READ) begin
              state_q <= TBP_READ;
              busy_q <= 1'b1;
            end
          end
        end
        TBP_WRITE, TBP_READ: begin
          cnt_q <= cnt_q + 8'h01;
          // Sample in the next-to-last low cycle, after two synchroniser stages and the
          // device's registered driver have let the answer settle.
          if (state_q == TBP_READ && cnt_q == 8'(HOLD_CYCLES)) begin
            rbyte_q <= link.d_level;
          end
          if (cnt_q == 8'(HOLD_CYCLES)) begin
            state_q <= TBP_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: state_q <= TBP_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pins: strobes low for one cycle more than the hold period, high otherwise.
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.e_mst_oe <= 3'h0;
      link.e_mst_out <= 3'h7;
      link.d_mst_oe <= 8'h00;
      link.d_mst_out <= 8'h00;
    end else begin
      link.e_mst_oe <= 3'h7;
      link.e_mst_out[tbp_pkg::BIT_CHIP_SELECT] <= (state_q == TBP_IDLE);
      link.e_mst_out[tbp_pkg::BIT_WRITE_STROBE] <= (state_q != TBP_WRITE);
      link.e_mst_out[tbp_pkg::BIT_READ_STROBE] <= (state_q != TBP_READ);
      link.d_mst_oe <= {8{state_q == TBP_WRITE}};
      link.d_mst_out <= wdata_q;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_rdata <= 8'h00;
    end else if (cmd_rd) begin
      cmd_rdata <= (cmd_addr == tbp_pkg::MADDR_DATA) ? rbyte_q : {7'h00, busy_q};
    end else begin
      cmd_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ==== tbp_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module tbp_asserts #(
  parameter int HOLD_CYCLES = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link signals
  input wire logic [7:0] d_dev_oe,
  input wire logic [2:0] e_dev_oe,
  input wire logic [7:0] d_mst_oe,
  input wire logic [2:0] e_mst_out,
  input wire logic [2:0] e_mst_oe
);
  // ------------------------------------------------------------
  // Link timing checks.
  // ------------------------------------------------------------
  // The rise may land at the nominal width or one cycle later, so only that slack is allowed.
  localparam int HOLD_LOW = HOLD_CYCLES - 1;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  property p_quiet_after_reset;
    $fell(sys_rst) |-> d_dev_oe == 8'h00 && e_dev_oe == 3'h0;
  endproperty
  a_quiet_after_reset: assert property (p_quiet_after_reset)
    else $error("device drives a pin straight after reset");
  property p_master_owns_e;
    $past(sys_rst) == 1'b0 |-> e_mst_oe == 3'h7;
  endproperty
  a_master_owns_e: assert property (p_master_owns_e)
    else $error("master released a strobe pin");
  property p_strobes_exclusive;
    !(e_mst_out[0] == 1'b0 && e_mst_out[1] == 1'b0);
  endproperty
  a_strobes_exclusive: assert property (p_strobes_exclusive)
    else $error("read and write strobes low together");
  property p_write_selected;
    !e_mst_out[1] |-> !e_mst_out[2];
  endproperty
  a_write_selected: assert property (p_write_selected)
    else $error("write strobe low without chip select");
  property p_read_selected;
    !e_mst_out[0] |-> !e_mst_out[2];
  endproperty
  a_read_selected: assert property (p_read_selected)
    else $error("read strobe low without chip select");
  property p_write_width;
    $fell(e_mst_out[1]) |-> ##HOLD_LOW !e_mst_out[1] ##[1:2] e_mst_out[1];
  endproperty
  a_write_width: assert property (p_write_width)
    else $error("write strobe width wrong");
  property p_read_width;
    $fell(e_mst_out[0]) |-> ##HOLD_LOW !e_mst_out[0] ##[1:2] e_mst_out[0];
  endproperty
  a_read_width: assert property (p_read_width)
    else $error("read strobe width wrong");
  property p_write_drives_data;
    !e_mst_out[1] |-> d_mst_oe == 8'hff;
  endproperty
  a_write_drives_data: assert property (p_write_drives_data)
    else $error("data bus not driven during write strobe");
  property p_no_bus_clash;
    (d_dev_oe & d_mst_oe) == 8'h00;
  endproperty
  a_no_bus_clash: assert property (p_no_bus_clash)
    else $error("both ends drive the data bus");
  property p_read_drive;
    $fell(e_mst_out[0]) |-> ##[2:5] d_dev_oe == 8'hff;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("device did not answer the read strobe");
  property p_read_release;
    $rose(e_mst_out[0]) |-> ##[2:5] d_dev_oe == 8'h00;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("device kept the data bus after the read");
endmodule
`default_nettype wire

// ==== three_bit_port_with_slave_port_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module three_bit_port_with_slave_port_control_bench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] cpu_addr = 3'h0;
  logic [7:0] cpu_wdata = 8'h00;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_rdata;
  logic [2:0] cmd_addr = 3'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [7:0] cmd_rdata;
  logic [7:0] seen;
  int n_errors = 0;
  int tests_run = 0;
  tbp_link_if link ();
  tbp_port_device i_tbp_port_device (.core_clk(core_clk), .sys_rst(sys_rst),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .link(link.device));
  tbp_port_master i_tbp_port_master (.core_clk(core_clk), .sys_rst(sys_rst),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_rdata(cmd_rdata), .link(link.master));
  tbp_asserts #(.HOLD_CYCLES(tbp_pkg::STROBE_CYCLES)) i_tbp_asserts (.core_clk(core_clk),
    .sys_rst(sys_rst), .d_dev_oe(link.d_dev_oe), .e_dev_oe(link.e_dev_oe),
    .d_mst_oe(link.d_mst_oe), .e_mst_out(link.e_mst_out), .e_mst_oe(link.e_mst_oe));
  always #20 core_clk = ~core_clk;
  // ------------------------------------------------------------
  // Bus tasks: m high selects the far-side master's command port.
  // ------------------------------------------------------------
  task automatic bus_write(input bit m, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cpu_addr <= a;
    cmd_addr <= a;
    cpu_wdata <= d;
    cmd_wdata <= d;
    cpu_wr <= !m;
    cmd_wr <= m;
    @(posedge core_clk);
    cpu_wr <= 1'b0;
    cmd_wr <= 1'b0;
  endtask
  task automatic bus_read(input bit m, input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    cpu_addr <= a;
    cmd_addr <= a;
    cpu_rd <= !m;
    cmd_rd <= m;
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    cmd_rd <= 1'b0;
    #1;
    d = m ? cmd_rdata : cpu_rdata;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic expect_reg(input logic [2:0] a, input logic [7:0] exp, input string what);
    bus_read(1'b0, a, seen);
    check(what, exp, seen);
  endtask
  // Polling is bounded so a master that never goes idle shows up as a mismatch.
  task automatic master_op(input logic [7:0] cmd, input logic [7:0] d);
    bus_write(1'b1, 3'h0, d);
    bus_write(1'b1, 3'h1, cmd);
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 40; i++) begin
      bus_read(1'b1, 3'h1, seen);
      if (seen[0] === 1'b0) break;
    end
    check("master busy", 8'h00, {7'h00, seen[0]});
    repeat (4) @(posedge core_clk);
  endtask
  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests.
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'h07, "dir ctrl reset");
    expect_reg(tbp_pkg::ADDR_D_DIRECTION, 8'hff, "d direction reset");
    expect_reg(tbp_pkg::ADDR_ANALOG_CONFIG, 8'h00, "analog reset");
    expect_reg(tbp_pkg::ADDR_E_PIN_VALUES, 8'h00, "e pins analog");
    bus_write(1'b0, tbp_pkg::ADDR_E_DIR_CTRL, 8'hc8);
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'h00, "dir ctrl read only bits");
    bus_write(1'b0, tbp_pkg::ADDR_E_OUTPUT_LATCH, 8'h05);
    expect_reg(tbp_pkg::ADDR_E_OUTPUT_LATCH, 8'h05, "e latch");
    expect_reg(tbp_pkg::ADDR_E_PIN_VALUES, 8'h00, "e pins analog driven");
    check("e wire analog", 8'h05, {5'h00, link.e_level});
    bus_write(1'b0, tbp_pkg::ADDR_ANALOG_CONFIG, 8'h07);
    expect_reg(tbp_pkg::ADDR_E_PIN_VALUES, 8'h05, "e pins output");
    bus_write(1'b0, tbp_pkg::ADDR_E_OUTPUT_LATCH, 8'h00);
    bus_write(1'b0, tbp_pkg::ADDR_E_DIR_CTRL, 8'h02);
    // Driver register plus two synchroniser stages before the pins read back.
    repeat (3) @(posedge core_clk);
    expect_reg(tbp_pkg::ADDR_E_PIN_VALUES, 8'h02, "e pins mixed");
    bus_write(1'b0, tbp_pkg::ADDR_D_DIRECTION, 8'h0f);
    bus_write(1'b0, tbp_pkg::ADDR_D_OUTPUT_LATCH, 8'ha5);
    repeat (3) @(posedge core_clk);
    expect_reg(tbp_pkg::ADDR_D_PIN_VALUES, 8'haf, "d pins mixed");
    expect_reg(tbp_pkg::ADDR_D_OUTPUT_LATCH, 8'ha5, "d latch");
    bus_write(1'b0, tbp_pkg::ADDR_E_PIN_VALUES, 8'h06);
    expect_reg(tbp_pkg::ADDR_E_OUTPUT_LATCH, 8'h06, "e pin write to latch");
    bus_write(1'b0, tbp_pkg::ADDR_D_DIRECTION, 8'hff);
    bus_write(1'b0, tbp_pkg::ADDR_E_DIR_CTRL, 8'h07);
    master_op(tbp_pkg::MCMD_WRITE, 8'h11);
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'h07, "no capture in io mode");
    expect_reg(tbp_pkg::ADDR_D_OUTPUT_LATCH, 8'ha5, "latch kept in io mode");
    bus_write(1'b0, tbp_pkg::ADDR_E_DIR_CTRL, 8'h17);
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'h17, "slave mode on");
    master_op(tbp_pkg::MCMD_WRITE, 8'h3c);
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'h97, "byte waiting");
    master_op(tbp_pkg::MCMD_WRITE, 8'h5a);
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'hb7, "overrun");
    expect_reg(tbp_pkg::ADDR_D_PIN_VALUES, 8'h5a, "received byte");
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'h37, "waiting cleared");
    bus_write(1'b0, tbp_pkg::ADDR_E_DIR_CTRL, 8'h17);
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'h17, "overrun cleared");
    bus_write(1'b0, tbp_pkg::ADDR_D_PIN_VALUES, 8'hc3);
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'h57, "byte pending");
    master_op(tbp_pkg::MCMD_READ, 8'h00);
    bus_read(1'b1, 3'h0, seen);
    check("far read", 8'hc3, seen);
    expect_reg(tbp_pkg::ADDR_E_DIR_CTRL, 8'h17, "pending cleared");
    final_report();
  end
endmodule
`default_nettype wire
